// >>> hdl/panel_pkg.sv
// Purpose: Shared constants for the tape drive panel exerciser.
// Assumes: One 100 MHz system clock.
// Notes: Times are given in their own unit and converted to cycles here.
package panel_pkg;
  localparam int unsigned clk_mhz = 100;
  localparam int unsigned debounce_us = 5;
  localparam int unsigned debounce_cycles = debounce_us * clk_mhz;
  localparam int unsigned bit_ns = 1000;
  localparam int unsigned bit_cycles = bit_ns * clk_mhz / 1000;
  localparam logic [7:0] test_pattern = 8'haa;
  localparam logic [3:0] bits_per_byte = 4'h8;
  localparam logic [2:0] rom_count = 3'h6;
  localparam logic [7:0] rom_words = 8'hff;
  localparam logic [15:0] reset_vector_hi = 16'hfffe;
  localparam logic [15:0] reset_vector_lo = 16'hffff;
  localparam logic [15:0] break_address = 16'hfffd;
  localparam logic [7:0] break_data = 8'h00;
  localparam logic [15:0] relocate_dest = 16'h0000;
  localparam logic [7:0] relocate_len = 8'h40;
  typedef enum logic [2:0] {
    fn_idle = 3'b000,
    fn_advance = 3'b001,
    fn_backup = 3'b010,
    fn_fast_return = 3'b011,
    fn_write = 3'b100,
    fn_read = 3'b101
  } func_e;
  typedef enum logic [2:0] {
    cpu_vec_hi = 3'b000,
    cpu_vec_lo = 3'b001,
    cpu_relocate = 3'b010,
    cpu_break = 3'b011,
    cpu_wait = 3'b100,
    cpu_sum = 3'b101,
    cpu_show = 3'b110
  } cpu_e;
endpackage

// >>> hdl/tape_drive_panel_exerciser.sv
// Purpose: Front-panel exerciser and ROM checksum sequencer for a cartridge tape drive.
// Assumes: Single clock, synchronous active-high reset, memories reached by simple ports.
// Notes: Memory reads return data in the same cycle the address is presented.
`timescale 1ns/1ps
module tape_drive_panel_exerciser
  import panel_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Front-panel keys, active high when pressed.
  input wire logic host_control_key,
  input wire logic advance_key,
  input wire logic backup_key,
  input wire logic fast_return_key,
  input wire logic pattern_write_key,
  input wire logic pattern_read_key,
  // Transport sensors.
  input wire logic cartridge_present,
  input wire logic end_of_tape,
  input wire logic beginning_of_tape,
  input wire logic read_clock_in,
  input wire logic read_data_in,
  // Motor and head controls.
  output logic motor_run_n,
  output logic forward_n,
  output logic fast_speed,
  output logic write_enable,
  output logic write_clock,
  output logic write_data,
  output logic read_window_flag,
  output logic [7:0] read_byte,
  output logic read_byte_valid,
  // Test controls.
  input wire logic start_key,
  input wire logic fixture_mem_enable,
  output logic fixture_mapped,
  // Memory port and displayed bus.
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic mem_write,
  output logic [7:0] mem_wdata,
  output logic [15:0] addr_display,
  output logic [7:0] data_display,
  output logic bus_halted_indicator,
  output logic address_match_halt
);

  // All state of the block, registered as one word.
  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] level;
    logic [10:0] prev;
    logic [175:0] count;
    func_e func;
    logic held;
    logic [7:0] shift;
    logic [3:0] bit_idx;
    logic [15:0] bit_timer;
    logic [1:0] cart_sync;
    logic [1:0] rdat_sync;
    logic [7:0] rshift;
    logic [3:0] rbits;
    cpu_e cpu;
    logic [15:0] pc;
    logic [7:0] idx;
    logic [7:0] sum;
    logic [2:0] rom;
    logic [15:0] start_vec;
    logic first_run;
    logic rd_pending;
    logic motor_run_n;
    logic forward_n;
    logic fast_speed;
    logic write_enable;
    logic write_clock;
    logic write_data;
    logic read_window_flag;
    logic [7:0] read_byte;
    logic read_byte_valid;
    logic fixture_mapped;
    logic [15:0] mem_addr;
    logic mem_write;
    logic [7:0] mem_wdata;
    logic [15:0] addr_display;
    logic [7:0] data_display;
    logic bus_halted_indicator;
    logic address_match_halt;
  } state_s;

  state_s r;
  state_s next_r;
  logic [10:0] pins;

  // Base address of each onboard ROM in checksum order.
  function automatic logic [15:0] rom_base(input logic [2:0] n);
    case (n)
      3'h0: rom_base = 16'h0800;
      3'h1: rom_base = 16'h0c00;
      3'h2: rom_base = 16'h1000;
      3'h3: rom_base = 16'h1400;
      3'h4: rom_base = 16'h1800;
      default: rom_base = 16'h1c00;
    endcase
  endfunction

  // Rising edge of a debounced key.
  function automatic logic pressed(input state_s s, input int k);
    pressed = s.level[k] & ~s.prev[k];
  endfunction

  assign pins = {read_clock_in, start_key, fixture_mem_enable, pattern_read_key,
                 pattern_write_key, fast_return_key, backup_key, advance_key,
                 host_control_key, end_of_tape, beginning_of_tape};

  // Next-state logic for the whole block.
  always_comb begin
    logic [15:0] cnt;
    logic want_run;
    logic any_key;
    func_e key_fn;
    cnt = 16'h0000;
    want_run = 1'b0;
    any_key = 1'b0;
    key_fn = fn_idle;
    next_r = r;
    next_r.sync1 = pins;
    next_r.sync2 = r.sync1;
    next_r.cart_sync = {r.cart_sync[0], cartridge_present}; // Two flops before use.
    next_r.rdat_sync = {r.rdat_sync[0], read_data_in}; // Two flops before use.
    next_r.prev = r.level;
    next_r.read_byte_valid = 1'b0;
    next_r.mem_write = 1'b0;
    // Keys and limit sensors settle before use; the read clock only passes the sync.
    for (int k = 0; k < 11; k++) begin
      cnt = r.count[k*16 +: 16];
      if (k == 10) begin
        next_r.level[k] = r.sync2[k];
      end else if (r.sync2[k] == r.level[k]) begin
        cnt = 16'h0000;
      end else if (cnt == 16'(debounce_cycles - 1)) begin
        next_r.level[k] = r.sync2[k];
        cnt = 16'h0000;
      end else begin
        cnt = cnt + 16'h0001;
      end
      next_r.count[k*16 +: 16] = cnt;
    end
    // Pick the newly pressed function key.
    if (pressed(r, 3)) begin
      key_fn = fn_advance;
    end else if (pressed(r, 4)) begin
      key_fn = fn_backup;
    end else if (pressed(r, 5)) begin
      key_fn = fn_fast_return;
    end else if (pressed(r, 6)) begin
      key_fn = fn_write;
    end else if (pressed(r, 7)) begin
      key_fn = fn_read;
    end
    any_key = key_fn != fn_idle;
    if (pressed(r, 2)) begin
      next_r.func = fn_idle;
    end else if (any_key) begin
      next_r.func = key_fn;
      next_r.held = r.level[2];
      next_r.shift = test_pattern;
      next_r.bit_idx = 4'h0;
    end else if (r.held && !r.level[2]) begin
      next_r.func = fn_idle;
    end else if (r.held) begin
      case (r.func)
        fn_advance: if (!r.level[3]) next_r.func = fn_idle;
        fn_backup: if (!r.level[4]) next_r.func = fn_idle;
        fn_fast_return: if (!r.level[5]) next_r.func = fn_idle;
        fn_write: if (!r.level[6]) next_r.func = fn_idle;
        fn_read: if (!r.level[7]) next_r.func = fn_idle;
        default: next_r.func = fn_idle;
      endcase
    end
    // Tape limits end motion on their own.
    if ((r.func == fn_advance || r.func == fn_write || r.func == fn_read) && r.level[1]) begin
      next_r.func = fn_idle;
    end
    if ((r.func == fn_backup || r.func == fn_fast_return) && r.level[0]) begin
      next_r.func = fn_idle;
    end
    // Motor outputs, active low run and forward.
    case (r.func)
      fn_advance: want_run = r.cart_sync[1];
      fn_backup: want_run = r.cart_sync[1];
      fn_fast_return: want_run = r.cart_sync[1];
      fn_write: want_run = 1'b1;
      fn_read: want_run = r.cart_sync[1];
      default: want_run = 1'b0;
    endcase
    next_r.motor_run_n = ~want_run;
    next_r.forward_n = ~(want_run && r.func != fn_backup && r.func != fn_fast_return);
    next_r.fast_speed = want_run && r.func == fn_fast_return;
    next_r.write_enable = r.func == fn_write;
    // Serialiser: one clock pulse per bit, eight per byte, pattern repeats.
    if (r.func == fn_write) begin
      if (r.bit_timer == 16'(bit_cycles - 1)) begin
        next_r.bit_timer = 16'h0000;
        next_r.write_clock = 1'b1;
        next_r.write_data = r.shift[7];
        if (r.bit_idx == bits_per_byte - 4'h1) begin
          next_r.bit_idx = 4'h0;
          next_r.shift = test_pattern;
        end else begin
          next_r.bit_idx = r.bit_idx + 4'h1;
          next_r.shift = {r.shift[6:0], 1'b0};
        end
      end else begin
        next_r.bit_timer = r.bit_timer + 16'h0001;
        if (r.bit_timer == 16'(bit_cycles / 2)) next_r.write_clock = 1'b0;
      end
    end else begin
      next_r.bit_timer = 16'h0000;
      next_r.write_clock = 1'b0;
      next_r.write_data = 1'b0;
    end
    // Read recovery on the rising read clock.
    next_r.read_window_flag = r.func == fn_read && r.cart_sync[1];
    if (r.read_window_flag && r.level[10] && !r.prev[10]) begin
      next_r.rshift = {r.rshift[6:0], r.rdat_sync[1]};
      if (r.rbits == bits_per_byte - 4'h1) begin
        next_r.rbits = 4'h0;
        next_r.read_byte = {r.rshift[6:0], r.rdat_sync[1]};
        next_r.read_byte_valid = 1'b1;
      end else begin
        next_r.rbits = r.rbits + 4'h1;
      end
    end else if (!r.read_window_flag) begin
      next_r.rbits = 4'h0;
    end
    // Fixture memory mapping follows its enable.
    next_r.fixture_mapped = r.level[8];
    // Test processor sequence.
    next_r.rd_pending = 1'b0;
    case (r.cpu)
      cpu_vec_hi: begin
        next_r.mem_addr = reset_vector_hi;
        next_r.rd_pending = 1'b1;
        if (r.rd_pending) begin
          next_r.start_vec[15:8] = mem_rdata;
          next_r.mem_addr = reset_vector_lo;
          next_r.cpu = cpu_vec_lo;
        end
      end
      cpu_vec_lo: begin
        next_r.rd_pending = 1'b1;
        if (r.rd_pending) begin
          next_r.start_vec[7:0] = mem_rdata;
          next_r.pc = {r.start_vec[15:8], mem_rdata};
          next_r.mem_addr = {r.start_vec[15:8], mem_rdata};
          next_r.idx = 8'h00;
          next_r.cpu = cpu_relocate;
        end
      end
      cpu_relocate: begin
        next_r.rd_pending = ~r.rd_pending;
        if (r.rd_pending) begin
          next_r.mem_addr = relocate_dest + 16'(r.idx);
          next_r.mem_wdata = mem_rdata;
          next_r.mem_write = 1'b1;
          next_r.idx = r.idx + 8'h01;
          if (r.idx == relocate_len - 8'h01) next_r.cpu = cpu_break;
        end else begin
          next_r.mem_addr = r.pc + 16'(r.idx);
        end
      end
      cpu_break: begin
        next_r.mem_addr = break_address;
        next_r.addr_display = break_address;
        next_r.data_display = break_data;
        next_r.address_match_halt = 1'b1;
        next_r.bus_halted_indicator = 1'b1;
        next_r.cpu = cpu_wait;
      end
      cpu_wait: begin
        if (pressed(r, 9) && !r.level[8]) begin
          if (!r.first_run) begin
            next_r.rom = (r.rom == rom_count - 3'h1) ? 3'h0 : r.rom + 3'h1;
          end
          next_r.first_run = 1'b0;
          next_r.idx = 8'h00;
          next_r.sum = 8'h00;
          next_r.bus_halted_indicator = 1'b0;
          next_r.address_match_halt = 1'b0;
          next_r.cpu = cpu_sum;
        end
      end
      cpu_sum: begin
        next_r.rd_pending = ~r.rd_pending;
        if (r.rd_pending) begin
          next_r.sum = r.sum + mem_rdata;
          next_r.idx = r.idx + 8'h01;
          if (r.idx == rom_words) next_r.cpu = cpu_show;
        end else begin
          next_r.mem_addr = rom_base(r.rom) + 16'(r.idx);
        end
      end
      cpu_show: begin
        next_r.addr_display = rom_base(r.rom);
        next_r.data_display = r.sum;
        next_r.bus_halted_indicator = 1'b1;
        next_r.cpu = cpu_wait;
      end
      default: next_r.cpu = cpu_vec_hi;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r <= '0;
      r.motor_run_n <= 1'b1;
      r.forward_n <= 1'b1;
      r.first_run <= 1'b1;
      r.func <= fn_idle;
      r.cpu <= cpu_vec_hi;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register.
  assign motor_run_n = r.motor_run_n;
  assign forward_n = r.forward_n;
  assign fast_speed = r.fast_speed;
  assign write_enable = r.write_enable;
  assign write_clock = r.write_clock;
  assign write_data = r.write_data;
  assign read_window_flag = r.read_window_flag;
  assign read_byte = r.read_byte;
  assign read_byte_valid = r.read_byte_valid;
  assign fixture_mapped = r.fixture_mapped;
  assign mem_addr = r.mem_addr;
  assign mem_write = r.mem_write;
  assign mem_wdata = r.mem_wdata;
  assign addr_display = r.addr_display;
  assign data_display = r.data_display;
  assign bus_halted_indicator = r.bus_halted_indicator;
  assign address_match_halt = r.address_match_halt;
endmodule

// >>> verification/panel_exerciser_checker.sv
// Purpose: Concurrent checks on the panel exerciser ports.
// Assumes: One clock domain with synchronous active-high reset.
// Notes: Limit counters stand in for the debounce span of the sensors.
`timescale 1ns/1ps
module panel_exerciser_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Transport side.
  input wire logic beginning_of_tape,
  input wire logic end_of_tape,
  input wire logic motor_run_n,
  input wire logic forward_n,
  input wire logic fast_speed,
  input wire logic write_enable,
  input wire logic write_clock,
  input wire logic write_data,
  input wire logic read_byte_valid,
  // Memory and display side.
  input wire logic mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] addr_display,
  input wire logic bus_halted_indicator
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [9:0] bot_cnt;
  logic [9:0] eot_cnt;
  // Counts how long each limit sensor has been high, saturating.
  always_ff @(posedge sys_clk) begin
    if (reset || !beginning_of_tape) bot_cnt <= 10'h000;
    else if (bot_cnt != 10'h3ff) bot_cnt <= bot_cnt + 10'h001;
    if (reset || !end_of_tape) eot_cnt <= 10'h000;
    else if (eot_cnt != 10'h3ff) eot_cnt <= eot_cnt + 10'h001;
  end
  sequence wc_rise;
    $rose(write_clock) && write_enable;
  endsequence
  sequence one_bit;
    wc_rise ##100 write_enable;
  endsequence
  sequence halt_drop;
    $fell(bus_halted_indicator);
  endsequence
  write_drive_a: assert property ($rose(write_enable) |-> ##[0:2] (!motor_run_n && !forward_n))
    else $error("write started without forward drive");
  fast_back_a: assert property ((fast_speed && !motor_run_n) |-> forward_n)
    else $error("fast motion not backward");
  bit_period_a: assert property (one_bit |-> $rose(write_clock))
    else $error("write clock period wrong");
  data_hold_a: assert property ((write_clock && $past(write_clock)) |-> $stable(write_data))
    else $error("write data moved while clock high");
  valid_pulse_a: assert property (read_byte_valid |=> !read_byte_valid)
    else $error("read valid longer than one cycle");
  copy_dest_a: assert property (mem_write |-> mem_addr < 16'h0040)
    else $error("copy wrote outside destination");
  halt_show_a: assert property (
    (bus_halted_indicator && $past(bus_halted_indicator)) |->
    addr_display inside {16'hfffd, 16'h0800, 16'h0c00, 16'h1000, 16'h1400, 16'h1800, 16'h1c00})
    else $error("halted with unexpected address shown");
  sum_time_a: assert property (halt_drop |-> ##[510:516] bus_halted_indicator)
    else $error("checksum did not halt in time");
  bot_stop_a: assert property ((bot_cnt > 10'h1fe) |-> !(fast_speed && !motor_run_n))
    else $error("fast return ran past beginning");
  eot_stop_a: assert property ((eot_cnt > 10'h1fe) |-> !(!motor_run_n && !forward_n))
    else $error("forward motion ran past end");
endmodule
bind tape_drive_panel_exerciser panel_exerciser_checker panel_exerciser_checker_inst (
  .sys_clk, .reset, .beginning_of_tape, .end_of_tape, .motor_run_n, .forward_n, .fast_speed,
  .write_enable, .write_clock, .write_data, .read_byte_valid, .mem_write, .mem_addr,
  .addr_display, .bus_halted_indicator);

// >>> verification/tape_transport_model.sv
// Purpose: Behavioural tape transport, head stream and memory for the exerciser.
// Assumes: Tape position resets mid-tape whenever the cartridge is out.
// Notes: Memory bytes equal the low address byte, zero where low equals high, apart from the start vector.
`timescale 1ns/1ps
module tape_transport_model
  import panel_pkg::*;
(
  // Clock.
  input wire logic sys_clk,
  // Drive commands and cartridge.
  input wire logic motor_run_n,
  input wire logic forward_n,
  input wire logic fast_speed,
  input wire logic cartridge_present,
  // Sensors and head stream.
  output logic end_of_tape,
  output logic beginning_of_tape,
  output logic read_clock_in,
  output logic read_data_in,
  // Memory port.
  input wire logic [15:0] mem_addr,
  input wire logic mem_write,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  int pos = 3000;
  int phase = 0;
  int bit_idx = 0;
  logic [7:0] ram[int];
  // Fixed contents, with the start vector in the two top cells.
  function automatic logic [7:0] rom_byte(input logic [15:0] a);
    if (a == 16'hfffe) return 8'h98;
    if (a == 16'hffff) return 8'h00;
    return (a[7:0] == a[15:8]) ? 8'h00 : a[7:0];
  endfunction
  initial begin
    {end_of_tape, beginning_of_tape, read_clock_in, read_data_in} = 4'h0;
  end
  // Moves the tape, raises the limit sensors, plays back the recorded pattern MSB first.
  always @(posedge sys_clk) begin
    if (!cartridge_present) pos = 3000;
    else if (!motor_run_n) pos = pos + (!forward_n ? 1 : (fast_speed ? -3 : -1));
    end_of_tape <= cartridge_present && pos >= 6000;
    beginning_of_tape <= cartridge_present && pos <= 0;
    if (!motor_run_n && !forward_n && cartridge_present) begin
      phase = (phase + 1) % 100;
      if (phase == 0) bit_idx = (bit_idx + 1) % 8;
      read_clock_in <= phase >= 50;
      read_data_in <= test_pattern[7 - bit_idx];
    end else begin
      phase = 0;
      bit_idx = 0;
      read_clock_in <= 1'b0;
      read_data_in <= ~read_data_in;
    end
  end
  // Stores writes on the clock; written bytes shadow the fixed contents.
  always @(posedge sys_clk) begin
    if (mem_write) ram[int'(mem_addr)] = mem_wdata;
  end
  // Answers reads in the cycle the address is shown, which is when the design takes them.
  always @(mem_addr or negedge sys_clk) begin
    mem_rdata = ram.exists(int'(mem_addr)) ? ram[int'(mem_addr)] : rom_byte(mem_addr);
  end
endmodule

// >>> verification/tape_drive_panel_exerciser_tb.sv
// Purpose: Self-checking bench for the tape drive panel exerciser.
// Assumes: Transport and memory come from tape_transport_model.
// Notes: Keys, apart from one short advance press, are held past the debounce span before results are read.
`timescale 1ns/1ps
module tape_drive_panel_exerciser_tb;
  import panel_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] keys = 7'h00;
  logic cartridge_present = 1'b1;
  logic fixture_mem_enable = 1'b1;
  logic end_of_tape, beginning_of_tape, read_clock_in, read_data_in, motor_run_n, forward_n;
  logic fast_speed, write_enable, write_clock, write_data, read_window_flag, read_byte_valid;
  logic fixture_mapped, mem_write, bus_halted_indicator, address_match_halt, wc_q, we_q;
  logic [7:0] read_byte, mem_rdata, mem_wdata, data_display, rb_last;
  logic [15:0] mem_addr, addr_display, base;
  logic [15:0] addr_q[$];
  int miscompares = 0;
  int total_checks = 0;
  int wc_count = 0;
  int rb_cnt = 0;
  int copies = 0;
  // Clock of 100 MHz.
  always #5 sys_clk = ~sys_clk;
  tape_drive_panel_exerciser tape_drive_panel_exerciser_inst (
    .sys_clk, .reset, .host_control_key(keys[0]), .advance_key(keys[1]),
    .backup_key(keys[2]), .fast_return_key(keys[3]), .pattern_write_key(keys[4]),
    .pattern_read_key(keys[5]), .start_key(keys[6]), .cartridge_present, .end_of_tape,
    .beginning_of_tape, .read_clock_in, .read_data_in, .motor_run_n, .forward_n, .fast_speed,
    .write_enable, .write_clock, .write_data, .read_window_flag, .read_byte, .read_byte_valid,
    .fixture_mem_enable, .fixture_mapped, .mem_addr, .mem_rdata, .mem_write, .mem_wdata,
    .addr_display, .data_display, .bus_halted_indicator, .address_match_halt);
  tape_transport_model tape_transport_model_inst (
    .sys_clk, .motor_run_n, .forward_n, .fast_speed, .cartridge_present, .end_of_tape,
    .beginning_of_tape, .read_clock_in, .read_data_in, .mem_addr, .mem_write, .mem_wdata,
    .mem_rdata);
  // Counts one comparison and reports a difference.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Sets a key and holds it past the debounce span plus a random margin.
  task automatic key(input int k, input logic v);
    keys[k] = v;
    cycles(520 + $urandom % 20);
  endtask
  task automatic motor(input logic run_n, input logic fwd_n, input logic fast);
    check(16'(motor_run_n), 16'(run_n));
    check(16'(forward_n), 16'(fwd_n));
    check(16'(fast_speed), 16'(fast));
  endtask
  task automatic wait_stop(input int lim);
    for (int i = 0; i < lim && motor_run_n !== 1'b1; i++) cycles(1);
    check(16'(motor_run_n), 16'h0001);
  endtask
  // Takes the cartridge out and back, which puts the tape mid-way.
  task automatic reload();
    cartridge_present = 1'b0;
    cycles(2);
    cartridge_present = 1'b1;
    cycles(20);
  endtask
  // Follows the bus, the copied bytes, the written bit stream and the bytes read back.
  always @(posedge sys_clk) begin
    if (!reset && mem_addr != 16'h0000 && addr_q.size() < 2) begin
      if (addr_q.size() == 0 || addr_q[$] != mem_addr) addr_q.push_back(mem_addr);
    end
    if (mem_write) begin
      copies++;
      check(16'(mem_wdata), 16'(mem_addr[7:0]));
    end
    if (write_enable && !we_q) wc_count = 0;
    if (write_clock && !wc_q) begin
      check(16'(write_data), 16'(test_pattern[7 - wc_count % 8]));
      wc_count++;
    end
    if (read_byte_valid) begin
      rb_last = read_byte;
      rb_cnt++;
    end
    wc_q <= write_clock;
    we_q <= write_enable;
  end
  initial begin
    void'($urandom(12));
    cycles(8);
    reset = 1'b0;
    for (int i = 0; i < 3000 && bus_halted_indicator !== 1'b1; i++) cycles(1);
    check(addr_q[0], 16'hfffe);
    check(addr_q[1], 16'hffff);
    check(addr_display, break_address);
    check(16'(data_display), 16'(break_data));
    check(16'(copies), 16'h0040);
    check(16'(address_match_halt), 16'h0001);
    check(mem_addr, break_address);
    cycles(520);
    check(16'(fixture_mapped), 16'h0001);
    fixture_mem_enable = 1'b0;
    cycles(520);
    check(16'(fixture_mapped), 16'h0000);
    for (int s = 0; s < 7; s++) begin
      base = 16'h0800 + 16'(s % 6) * 16'h0400;
      key(6, 1'b1);
      key(6, 1'b0);
      check(16'(bus_halted_indicator), 16'h0001);
      check(addr_display, base);
      check(16'(data_display), 16'(8'h80 - base[15:8]));
      check(16'(address_match_halt), 16'h0000);
    end
    keys[1] = 1'b1;
    cycles(100 + $urandom % 300);
    keys[1] = 1'b0;
    cycles(600);
    check(16'(motor_run_n), 16'h0001);
    key(1, 1'b1);
    key(1, 1'b0);
    motor(1'b0, 1'b0, 1'b0);
    wait_stop(5000);
    reload();
    key(2, 1'b1);
    key(2, 1'b0);
    motor(1'b0, 1'b1, 1'b0);
    key(3, 1'b1);
    motor(1'b0, 1'b1, 1'b1);
    key(3, 1'b0);
    wait_stop(3000);
    reload();
    key(4, 1'b1);
    key(4, 1'b0);
    check(16'(write_enable), 16'h0001);
    cycles(1000);
    key(0, 1'b1);
    check(16'(motor_run_n), 16'h0001);
    check(16'(write_enable), 16'h0000);
    reload();
    key(1, 1'b1);
    motor(1'b0, 1'b0, 1'b0);
    key(1, 1'b0);
    check(16'(motor_run_n), 16'h0001);
    key(0, 1'b0);
    cartridge_present = 1'b0;
    key(4, 1'b1);
    motor(1'b0, 1'b0, 1'b0);
    key(4, 1'b0);
    key(0, 1'b1);
    key(0, 1'b0);
    reload();
    rb_cnt = 0;
    key(5, 1'b1);
    key(5, 1'b0);
    cycles(400);
    check(16'(read_window_flag), 16'h0001);
    check(16'(rb_cnt > 0), 16'h0001);
    check(16'(rb_last), 16'(test_pattern));
    key(0, 1'b1);
    key(0, 1'b0);
    conclude();
  end
  // Cuts a hung run short.
  initial begin
    cycles(80000);
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
